/* rtl/cpg_pkg.sv */
/*
 * Shared constants and types of the counter pattern generator and checker.
 * Assumes a 32-bit lane fabric interface with a per-byte control flag.
 */
package cpg_pkg;

   // =========================================================================
   // Register map, byte addresses on the Avalon-MM slave.
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_COUNT = 4'h8;

   // =========================================================================
   // Field positions.
   localparam int CTRL_INJECT_BIT = 0;
   localparam int CTRL_CLEAR_BIT = 1;
   localparam int STAT_ERROR_BIT = 0;
   localparam int STAT_LOCK_BIT = 1;
   localparam int STAT_STARTED_BIT = 2;
   localparam int STAT_LANE_OK_BIT = 3;

   // =========================================================================
   // Pattern constants and reset values.
   localparam logic [7:0] K28_5 = 8'hBC;
   localparam logic [31:0] COMMA_WORD = {24'h00_0000, K28_5};
   localparam logic [3:0] COMMA_KMASK = 4'h1;
   localparam logic [3:0] DATA_KMASK = 4'h0;
   localparam logic [31:0] INJECT_WORD = 32'hFFFF_FFEF;
   localparam logic [31:0] COUNT_MAX = 32'hFFFF_FFFF;
   localparam logic [31:0] WORD_RESET = 32'h0000_0000;
   localparam int PKT_LEN_DEFAULT = 16;
   localparam int FIFO_AW = 2;
   localparam int FIFO_DEPTH = 4;

   // =========================================================================
   // Types.
   typedef enum logic {GEN_COMMA, GEN_PAYLOAD} cpg_gen_state_type;

   typedef struct packed {
      logic lock;
      logic error;
      logic [31:0] count;
   } cpg_status_type;

   typedef struct packed {
      logic [3:0] address;
      logic [3:0] byteenable;
      logic read;
      logic write;
      logic [31:0] writedata;
   } cpg_bus_req_type;

   typedef struct packed {
      logic [2:0] lane_sync;
      cpg_gen_state_type gen_state;
      logic [15:0] payload_left;
      logic [31:0] tx_count;
      logic [31:0] tx_data;
      logic [3:0] tx_k;
      logic chk_started;
      logic chk_resync;
      logic [31:0] expected;
      logic err;
      logic lock;
      logic [31:0] count;
      logic inject;
      logic bus_ack;
      logic [31:0] readdata;
      logic [FIFO_DEPTH-1:0][33:0] fifo_mem;
      logic [FIFO_AW:0] wr_bin;
      logic [FIFO_AW:0] wr_gray;
      logic [FIFO_AW:0] rd_gray_s1;
      logic [FIFO_AW:0] rd_gray_s2;
      logic [33:0] last_push;
   } cpg_lane_state_type;

   typedef struct packed {
      logic [FIFO_AW:0] rd_bin;
      logic [FIFO_AW:0] rd_gray;
      logic [FIFO_AW:0] wr_gray_s1;
      logic [FIFO_AW:0] wr_gray_s2;
   } cpg_uart_state_type;

endpackage : cpg_pkg

/* rtl/cpg_pattern_gen_check.sv */
/*
 * Counter pattern generator and checker for one 8b10b transceiver lane,
 * with an Avalon-MM register slave and a status FIFO into the UART domain.
 * Assumes the lane transmit and receive fabric clocks are both ref_clk and
 * that uart_clk is the 125 MHz UART clock made from the 160 MHz oscillator.
 */
`timescale 1ns/1ns

// What this block does
// - Send a 32-bit counter pattern into the 8b10b transmit path.
// - Put one K28.5 comma word between consecutive packets.
// - Payload words count up by one from word to word.
// - Compare each received payload word, except the first after a comma, with the expected count; flag errors.
// - Active-high inject makes the generator corrupt transmitted words.
// - Active-high clear sets the 32-bit error count back to zero, or to one when a bad word arrives in the same cycle.
// - Lane data is ignored while the lane coding reset is low.
// - Status reaches the UART domain through a gray-pointer FIFO.
// - The UART side runs on the 125 MHz UART clock.
// - Injection sends FFFFFFEF instead of the count; error count rises.
// - The checker stays idle until the first valid received word.
module cpg_pattern_gen_check #(
   parameter int PKT_LEN = cpg_pkg::PKT_LEN_DEFAULT
) (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic uart_clk,
   // Lane side.
   input wire logic lane_coding_async_rst_n,
   input wire logic lane_rx_word_valid,
   input wire logic [31:0] lane_rx_data,
   input wire logic [3:0] lane_rx_k,
   output logic [31:0] lane_tx_data,
   output logic [3:0] lane_tx_k,
   // Avalon-MM register slave.
   input wire logic [3:0] avs_address,
   input wire logic [3:0] avs_byteenable,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Checker flags in the lane domain.
   output logic error_flag,
   output logic data_lock,
   output logic [31:0] error_count,
   // Status stream in the UART domain.
   output logic uart_status_valid,
   input wire logic uart_status_ready,
   output cpg_pkg::cpg_status_type uart_status
);

   // =========================================================================
   // Reset release, two flip-flops per domain.
   logic [1:0] ref_rst_sync;
   logic [1:0] uart_rst_sync;
   logic rst_n;
   logic uart_rst_n;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ref_rst_sync <= 2'h0;
      end else begin
         ref_rst_sync <= {ref_rst_sync[0], 1'b1};
      end
   end

   always_ff @(posedge uart_clk or negedge rstn) begin
      if (!rstn) begin
         uart_rst_sync <= 2'h0;
      end else begin
         uart_rst_sync <= {uart_rst_sync[0], 1'b1};
      end
   end

   assign rst_n = ref_rst_sync[1];
   assign uart_rst_n = uart_rst_sync[1];

   // =========================================================================
   // Lane domain.
   cpg_pkg::cpg_lane_state_type lane;
   cpg_pkg::cpg_lane_state_type next_lane;
   cpg_pkg::cpg_uart_state_type ust;
   cpg_pkg::cpg_uart_state_type next_ust;
   cpg_pkg::cpg_bus_req_type req;
   cpg_pkg::cpg_status_type snap;
   logic lane_ok;
   logic fifo_full;
   logic fifo_empty;
   logic is_comma;
   logic rx_take;
   logic mismatch;
   logic do_clear;
   logic [cpg_pkg::FIFO_AW:0] next_wr_bin;
   logic [cpg_pkg::FIFO_AW:0] next_rd_bin;
   logic [cpg_pkg::FIFO_AW-1:0] rd_idx;

   assign req = '{avs_address, avs_byteenable, avs_read, avs_write,
                  avs_writedata};
   // The lane is usable only once the second and third stages agree high.
   assign lane_ok = lane.lane_sync[1] & lane.lane_sync[2];
   assign rx_take = lane_ok & lane_rx_word_valid;
   assign is_comma = (lane_rx_k == cpg_pkg::COMMA_KMASK) &&
                     (lane_rx_data[7:0] == cpg_pkg::K28_5);
   assign mismatch = rx_take & lane.chk_started & ~is_comma &
                     ~lane.chk_resync &
                     (lane_rx_data != lane.expected);
   // A write lands at the edge that completes the transfer, not before.
   assign do_clear = req.write & lane.bus_ack &
                     (req.address == cpg_pkg::ADDR_CTRL) &
                     req.byteenable[0] &
                     req.writedata[cpg_pkg::CTRL_CLEAR_BIT];
   assign snap = '{lane.lock, lane.err, lane.count};
   assign fifo_full = lane.wr_gray ==
      {~lane.rd_gray_s2[cpg_pkg::FIFO_AW:cpg_pkg::FIFO_AW-1],
       lane.rd_gray_s2[cpg_pkg::FIFO_AW-2:0]};
   assign next_wr_bin = lane.wr_bin + 1'b1;

   always_comb begin
      next_lane = lane;
      next_lane.lane_sync = {lane.lane_sync[1:0], lane_coding_async_rst_n};

      // Generator: comma, then PKT_LEN payload words, repeated.
      if (!lane_ok) begin
         next_lane.gen_state = cpg_pkg::GEN_COMMA;
         next_lane.tx_data = cpg_pkg::COMMA_WORD;
         next_lane.tx_k = cpg_pkg::COMMA_KMASK;
      end else begin
         case (lane.gen_state)
            cpg_pkg::GEN_COMMA: begin
               next_lane.tx_data = cpg_pkg::COMMA_WORD;
               next_lane.tx_k = cpg_pkg::COMMA_KMASK;
               next_lane.payload_left = 16'(PKT_LEN);
               next_lane.gen_state = cpg_pkg::GEN_PAYLOAD;
            end
            cpg_pkg::GEN_PAYLOAD: begin
               next_lane.tx_k = cpg_pkg::DATA_KMASK;
               next_lane.tx_data = lane.inject ? cpg_pkg::INJECT_WORD
                                               : lane.tx_count;
               next_lane.tx_count = lane.tx_count + 32'h0000_0001;
               next_lane.payload_left = lane.payload_left - 16'h0001;
               if (lane.payload_left == 16'h0001) begin
                  next_lane.gen_state = cpg_pkg::GEN_COMMA;
               end
            end
            default: begin
               next_lane.gen_state = cpg_pkg::GEN_COMMA;
            end
         endcase
      end

      // Checker.
      next_lane.err = mismatch;
      if (!lane_ok) begin
         next_lane.chk_started = 1'b0;
         next_lane.lock = 1'b0;
      end else if (rx_take) begin
         next_lane.chk_started = 1'b1;
         if (is_comma) begin
            next_lane.chk_resync = 1'b1;
         end else begin
            // The first word after start seeds the expected value as well.
            next_lane.chk_resync = 1'b0;
            next_lane.expected = lane_rx_data + 32'h0000_0001;
            next_lane.lock = ~mismatch;
         end
      end
      // A clear that meets a bad word leaves that word counted.
      if (do_clear && mismatch) begin
         next_lane.count = 32'h0000_0001;
      end else if (do_clear) begin
         next_lane.count = cpg_pkg::WORD_RESET;
      end else if (mismatch && lane.count != cpg_pkg::COUNT_MAX) begin
         next_lane.count = lane.count + 32'h0000_0001;
      end

      // Register slave: one wait cycle, then the answer.
      next_lane.bus_ack = (req.read | req.write) & ~lane.bus_ack;
      if (req.write && lane.bus_ack && req.byteenable[0] &&
          req.address == cpg_pkg::ADDR_CTRL) begin
         next_lane.inject = req.writedata[cpg_pkg::CTRL_INJECT_BIT];
      end
      if (req.read && !lane.bus_ack) begin
         case (req.address)
            cpg_pkg::ADDR_CTRL: begin
               next_lane.readdata = {31'h0000_0000, lane.inject};
            end
            cpg_pkg::ADDR_STATUS: begin
               next_lane.readdata = {28'h000_0000, lane_ok,
                                     lane.chk_started, lane.lock, lane.err};
            end
            cpg_pkg::ADDR_COUNT: begin
               next_lane.readdata = lane.count;
            end
            default: begin
               next_lane.readdata = cpg_pkg::WORD_RESET;
            end
         endcase
      end

      // Status FIFO write side: push a snapshot whenever status differs from the last one pushed and the FIFO is not full.
      next_lane.rd_gray_s1 = ust.rd_gray;
      next_lane.rd_gray_s2 = lane.rd_gray_s1;
      if (snap != lane.last_push && !fifo_full) begin
         next_lane.fifo_mem[lane.wr_bin[cpg_pkg::FIFO_AW-1:0]] = snap;
         next_lane.last_push = snap;
         next_lane.wr_bin = next_wr_bin;
         next_lane.wr_gray = next_wr_bin ^ (next_wr_bin >> 1);
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         lane <= '0;
      end else begin
         lane <= next_lane;
      end
   end

   // =========================================================================
   // UART domain: FIFO read side.
   assign fifo_empty = ust.rd_gray == ust.wr_gray_s2;
   assign next_rd_bin = ust.rd_bin + 1'b1;
   assign rd_idx = ust.rd_bin[cpg_pkg::FIFO_AW-1:0];

   always_comb begin
      next_ust = ust;
      next_ust.wr_gray_s1 = lane.wr_gray;
      next_ust.wr_gray_s2 = ust.wr_gray_s1;
      if (!fifo_empty && uart_status_ready) begin
         next_ust.rd_bin = next_rd_bin;
         next_ust.rd_gray = next_rd_bin ^ (next_rd_bin >> 1);
      end
   end

   always_ff @(posedge uart_clk or negedge uart_rst_n) begin
      if (!uart_rst_n) begin
         ust <= '0;
      end else begin
         ust <= next_ust;
      end
   end

   // =========================================================================
   // Outputs.
   assign lane_tx_data = lane.tx_data;
   assign lane_tx_k = lane.tx_k;
   assign avs_readdata = lane.readdata;
   assign avs_waitrequest = (avs_read | avs_write) & ~lane.bus_ack;
   assign error_flag = lane.err;
   assign data_lock = lane.lock;
   assign error_count = lane.count;
   assign uart_status_valid = ~fifo_empty;
   assign uart_status = lane.fifo_mem[rd_idx];

endmodule : cpg_pattern_gen_check

/* verification/cpg_lane_model.sv */
/* Loopback model of the transceiver lane in 8b10b mode.
   Assumes the bench enables receive valid once the lane is wanted. */
`timescale 1ns/1ns
module cpg_lane_model (
   // Clock and control.
   input wire logic clk,
   input wire logic rx_en,
   // Fabric side.
   input wire logic [31:0] tx_data,
   input wire logic [3:0] tx_k,
   output logic rx_valid,
   output logic [31:0] rx_data,
   output logic [3:0] rx_k
);
   // ==========
   // Return path
   initial begin
      rx_valid = 1'b0;
      rx_data = 32'h0000_0000;
      rx_k = 4'h0;
   end
   // Idle data toggles so that a stale word never passes for a good one.
   always @(posedge clk) begin
      rx_valid <= rx_en;
      rx_data <= rx_en ? tx_data : ~rx_data;
      rx_k <= rx_en ? tx_k : ~rx_k;
   end
endmodule : cpg_lane_model

/* verification/cpg_pattern_gen_check_props.sv */
/* Port assertions of the pattern generator and checker.
   Assumes it is bound into the top module and sees its ports. */
`timescale 1ns/1ns
module cpg_pattern_gen_check_props #(
   parameter int PKT_LEN = 16
) (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rstn,
   // Lane side.
   input wire logic lane_coding_async_rst_n,
   input wire logic lane_rx_word_valid,
   input wire logic [31:0] lane_tx_data,
   input wire logic [3:0] lane_tx_k,
   // Checker flags.
   input wire logic error_flag,
   input wire logic data_lock,
   input wire logic [31:0] error_count
);
   logic [15:0] run;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // ==========
   // Payload words since the last comma
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         run <= 16'h0000;
      end else begin
         run <= (lane_tx_k != 4'h0) ? 16'h0000 : run + 16'h0001;
      end
   end
   comma_form_a: assert property (
      lane_tx_k != 4'h0 |-> lane_tx_k == cpg_pkg::COMMA_KMASK &&
      lane_tx_data == cpg_pkg::COMMA_WORD) else $error("bad comma");
   packet_len_a: assert property (
      run <= PKT_LEN) else $error("packet too long");
   payload_step_a: assert property (
      lane_tx_k == 4'h0 && $past(lane_tx_k) == 4'h0 &&
      $past(lane_tx_data) != 32'h0000_0000 &&
      lane_tx_data != cpg_pkg::INJECT_WORD &&
      $past(lane_tx_data) != cpg_pkg::INJECT_WORD |->
      lane_tx_data == $past(lane_tx_data) + 32'h0000_0001)
      else $error("payload not counting");
   count_step_a: assert property (
      error_flag && error_count != 32'h0000_0001 |->
      error_count == $past(error_count) + 32'h0000_0001 ||
      error_count == cpg_pkg::COUNT_MAX) else $error("count step");
   count_hold_a: assert property (
      !error_flag && error_count != 32'h0000_0000 |-> $stable(error_count))
      else $error("count moved");
   error_lock_a: assert property (
      error_flag |-> !data_lock) else $error("lock on error");
   idle_check_a: assert property (
      !lane_rx_word_valid |=> !error_flag) else $error("error when idle");
   lane_reset_a: assert property (
      !lane_coding_async_rst_n [*4] |=> !data_lock &&
      lane_tx_k == cpg_pkg::COMMA_KMASK) else $error("lane reset ignored");
endmodule : cpg_pattern_gen_check_props

bind cpg_pattern_gen_check cpg_pattern_gen_check_props #(.PKT_LEN(PKT_LEN))
   u_props (.ref_clk(ref_clk), .rstn(rstn),
   .lane_coding_async_rst_n(lane_coding_async_rst_n),
   .lane_rx_word_valid(lane_rx_word_valid), .lane_tx_data(lane_tx_data),
   .lane_tx_k(lane_tx_k), .error_flag(error_flag), .data_lock(data_lock),
   .error_count(error_count));

/* verification/cpg_pattern_gen_check_test.sv */
/* Self-checking bench of the pattern generator and checker.
   Assumes the lane model loops transmit words back to the receiver. */
`timescale 1ns/1ns
module cpg_pattern_gen_check_test;
   localparam int PL = 4;
   logic ref_clk = 1'b0;
   logic uart_clk = 1'b0;
   logic rstn = 1'b0;
   logic lane_coding_async_rst_n = 1'b0;
   logic rx_en = 1'b0;
   logic lane_rx_word_valid;
   logic [31:0] lane_rx_data, lane_tx_data, avs_readdata, error_count, q, w;
   logic [3:0] lane_rx_k, lane_tx_k;
   logic [3:0] avs_address = 4'h0;
   logic [3:0] avs_byteenable = 4'hF;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic avs_waitrequest, error_flag, data_lock, uart_status_valid;
   logic uart_status_ready = 1'b0;
   cpg_pkg::cpg_status_type uart_status, last;
   int errors = 0;
   int tests_run = 0;
   int cycles = 0;
   int err_pulses = 0;
   int n;
   always #2 ref_clk = ~ref_clk;
   always #4 uart_clk = ~uart_clk;
   cpg_pattern_gen_check #(.PKT_LEN(PL)) uut (.ref_clk, .rstn, .uart_clk,
      .lane_coding_async_rst_n, .lane_rx_word_valid, .lane_rx_data,
      .lane_rx_k, .lane_tx_data, .lane_tx_k, .avs_address, .avs_byteenable,
      .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
      .error_flag, .data_lock, .error_count, .uart_status_valid,
      .uart_status_ready, .uart_status);
   cpg_lane_model lane (.clk(ref_clk), .rx_en, .tx_data(lane_tx_data),
      .tx_k(lane_tx_k), .rx_valid(lane_rx_word_valid), .rx_data(lane_rx_data),
      .rx_k(lane_rx_k));
   // ==========
   // Tasks
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_sim
   task automatic chk(input string s, input logic [31:0] e, g);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   // Holds the request until waitrequest is seen low at a falling edge, then drops it after the next rising edge.
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= d;
      @(negedge ref_clk);
      while (avs_waitrequest !== 1'b0) @(negedge ref_clk);
      @(posedge ref_clk);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   always @(negedge ref_clk) begin
      if (error_flag === 1'b1) err_pulses++;
   end
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         errors++;
         end_sim;
      end
   end
   // ==========
   // Tests
   initial begin
      repeat (5) @(posedge ref_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge ref_clk);
      bus(1'b0, cpg_pkg::ADDR_STATUS, 32'h0);
      chk("status", 32'h0000_0000, q);
      chk("comma k", 32'h1, {28'h0, lane_tx_k});
      lane_coding_async_rst_n <= 1'b1;
      repeat (8) @(posedge ref_clk);
      chk("lock idle", 32'h0, {31'h0, data_lock});
      rx_en <= 1'b1;
      repeat (4 * PL) @(posedge ref_clk);
      bus(1'b0, cpg_pkg::ADDR_STATUS, 32'h0);
      chk("status", 32'h0000_000E, q);
      bus(1'b0, cpg_pkg::ADDR_COUNT, 32'h0);
      chk("count start", 32'h0, q);
      @(negedge ref_clk);
      while (lane_tx_k === 4'h0) @(negedge ref_clk);
      @(negedge ref_clk);
      w = lane_tx_data;
      for (int i = 1; i < PL; i++) begin
         @(negedge ref_clk);
         chk("payload", w + 32'(i), lane_tx_data);
      end
      bus(1'b1, cpg_pkg::ADDR_CTRL, 32'h0000_0001);
      n = 0;
      while (lane_tx_data !== cpg_pkg::INJECT_WORD && n < 20) begin
         @(negedge ref_clk);
         n++;
      end
      chk("inject", cpg_pkg::INJECT_WORD, lane_tx_data);
      bus(1'b1, cpg_pkg::ADDR_CTRL, 32'h0);
      repeat (4 * PL) @(posedge ref_clk);
      bus(1'b0, cpg_pkg::ADDR_COUNT, 32'h0);
      chk("count", 32'h1, {31'h0, q != 32'h0});
      chk("count pulses", 32'(err_pulses), q);
      chk("lock", 32'h1, {31'h0, data_lock});
      bus(1'b1, cpg_pkg::ADDR_CTRL, 32'h0000_0002);
      bus(1'b0, cpg_pkg::ADDR_COUNT, 32'h0);
      chk("cleared", 32'h0, q);
      bus(1'b0, cpg_pkg::ADDR_CTRL, 32'h0);
      chk("ctrl", 32'h0, q);
      bus(1'b0, 4'hC, 32'h0);
      chk("unmapped", 32'h0, q);
      @(posedge uart_clk);
      uart_status_ready <= 1'b1;
      repeat (40) begin
         @(negedge uart_clk);
         if (uart_status_valid === 1'b1) last = uart_status;
      end
      chk("uart count", 32'h0, last.count);
      chk("uart lock", 32'h1, {31'h0, last.lock});
      chk("uart error", 32'h0, {31'h0, last.error});
      @(posedge ref_clk);
      lane_coding_async_rst_n <= 1'b0;
      repeat (6) @(posedge ref_clk);
      chk("lock", 32'h0, {31'h0, data_lock});
      end_sim;
   end
endmodule : cpg_pattern_gen_check_test
